//--- design/pbs_pkg.sv
// package of constants for the bridge primary status register
package pbs_pkg;
    localparam logic [7:0]  PBS_STATUS_OFFSET  = 8'h84;
    localparam logic [7:0]  PBS_SPLIT_OFFSET   = 8'h8c;
    localparam logic [3:0]  PBS_CMD_CFG_WRITE  = 4'hb;
    localparam logic [3:0]  PBS_CMD_CFG_READ   = 4'ha;
    localparam logic [2:0]  PBS_FUNC_RESET     = 3'h0;
    localparam logic [4:0]  PBS_DEV_RESET      = 5'h1f;
    localparam logic [7:0]  PBS_BUS_RESET      = 8'hff;
    localparam logic [15:0] PBS_LIMIT_RESET    = 16'h0010;
    localparam logic [15:0] PBS_LIMIT_ALL      = 16'hffff;
    localparam logic [15:0] PBS_CAP_VALUE      = 16'h0010;
    localparam int          PBS_FUNC_LSB       = 0;
    localparam int          PBS_DEV_LSB        = 3;
    localparam int          PBS_BUS_LSB        = 8;
    localparam int          PBS_WIDE_BIT       = 16;
    localparam int          PBS_FAST_BIT       = 17;
    localparam int          PBS_DISCARD_BIT    = 18;
    localparam int          PBS_UNEXP_BIT      = 19;
    localparam int          PBS_OVERRUN_BIT    = 20;
    localparam int          PBS_DELAY_BIT      = 21;
    localparam int          PBS_LIMIT_LSB      = 16;
    localparam int          PBS_AD_FUNC_LSB    = 8;
    localparam int          PBS_AD_DEV_LSB     = 11;
endpackage : pbs_pkg

//--- design/pbs_cfg_decode.sv
// configuration address phase decoder
`timescale 1ns/100ps
`default_nettype none
module pbs_cfg_decode
    import pbs_pkg::*;
(
    input  wire logic        cfg_valid_i,
    input  wire logic [3:0]  cfg_cmd_i,
    input  wire logic        cfg_idsel_i,
    input  wire logic [31:0] cfg_addr_i,
    input  wire logic [2:0]  own_func_i,
    output logic             hit_write_o,
    output logic             hit_read_o,
    output logic [7:0]       reg_offset_o
);
    // type 0 hit: idsel, ad[1:0] zero, function matches
    wire logic type0_hit;
    assign type0_hit    = cfg_valid_i && cfg_idsel_i && (cfg_addr_i[1:0] == 2'h0)
                        && (cfg_addr_i[PBS_AD_FUNC_LSB +: 3] == own_func_i);
    assign hit_write_o  = type0_hit && (cfg_cmd_i == PBS_CMD_CFG_WRITE);
    assign hit_read_o   = type0_hit && (cfg_cmd_i == PBS_CMD_CFG_READ);
    assign reg_offset_o = {cfg_addr_i[7:2], 2'h0};
endmodule : pbs_cfg_decode
`default_nettype wire

//--- design/pbs_limit_check.sv
// split request commitment limit check
`timescale 1ns/100ps
`default_nettype none
module pbs_limit_check
    import pbs_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic [W-1:0] limit_i,
    input  wire logic [W-1:0] committed_i,
    input  wire logic [W-1:0] req_size_i,
    output logic              fits_o
);
    // sum kept one bit wider so no wrap hides an overflow
    wire logic [W:0] total;
    assign total  = {1'b0, committed_i} + {1'b0, req_size_i};
    assign fits_o = (limit_i == PBS_LIMIT_ALL[W-1:0]) || (total <= {1'b0, limit_i});
endmodule : pbs_limit_check
`default_nettype wire

//--- design/pbs_status_reg.sv
// bridge primary status register with split error flags
`timescale 1ns/100ps
`default_nettype none
module pbs_status_reg
    import pbs_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        reverse_mode_i,
    input  wire logic        wide_request_strap_n_i,
    input  wire logic        cfg_valid_i,
    input  wire logic [3:0]  cfg_cmd_i,
    input  wire logic        cfg_idsel_i,
    input  wire logic [31:0] cfg_addr_i,
    input  wire logic [31:0] cfg_wdata_i,
    input  wire logic [3:0]  cfg_be_i,
    input  wire logic [7:0]  primary_bus_i,
    input  wire logic        mixed_mode_i,
    input  wire logic        cpl_discard_i,
    input  wire logic        cpl_arrive_i,
    input  wire logic [15:0] cpl_req_id_i,
    input  wire logic        cpl_overrun_i,
    input  wire logic        split_req_i,
    input  wire logic [15:0] split_req_size_i,
    input  wire logic [15:0] split_committed_i,
    output logic [31:0]      cfg_rdata_o,
    output logic             cfg_rvalid_o,
    output logic [15:0]      completer_id_o,
    output logic             split_fwd_o
);
    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [2:0]  func_num;
    logic [4:0]  dev_num;
    logic        wide_flag;
    logic        discard_flag;
    logic        unexp_flag;
    logic        overrun_flag;
    logic        delay_flag;
    logic [15:0] split_limit;
    logic        rst_q;

    ////////////////////////////////////////////////////////////////////////////
    // address decode
    wire logic       hit_write;
    wire logic       hit_read;
    wire logic [7:0] reg_offset;

    pbs_cfg_decode u_decode (
        .cfg_valid_i  (cfg_valid_i),
        .cfg_cmd_i    (cfg_cmd_i),
        .cfg_idsel_i  (cfg_idsel_i),
        .cfg_addr_i   (cfg_addr_i),
        .own_func_i   (func_num),
        .hit_write_o  (hit_write),
        .hit_read_o   (hit_read),
        .reg_offset_o (reg_offset)
    );

    // register selects and w1c strobes (byte lane 2 holds bits 23:16)
    wire logic wr_status;
    wire logic wr_split;
    wire logic clr_lane;
    assign wr_status = hit_write && (reg_offset == PBS_STATUS_OFFSET);
    assign wr_split  = hit_write && (reg_offset == PBS_SPLIT_OFFSET);
    assign clr_lane  = wr_status && cfg_be_i[2];

    wire logic clr_discard;
    wire logic clr_unexp;
    wire logic clr_overrun;
    wire logic clr_delay;
    assign clr_discard = clr_lane && cfg_wdata_i[PBS_DISCARD_BIT];
    assign clr_unexp   = clr_lane && cfg_wdata_i[PBS_UNEXP_BIT];
    assign clr_overrun = clr_lane && cfg_wdata_i[PBS_OVERRUN_BIT];
    assign clr_delay   = clr_lane && cfg_wdata_i[PBS_DELAY_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // event sources
    wire logic [15:0] own_id;
    wire logic        fits;
    wire logic        unexp_evt;
    wire logic        delay_evt;
    assign own_id    = {primary_bus_i, dev_num, func_num};
    assign unexp_evt = cpl_arrive_i && (cpl_req_id_i == own_id);
    assign delay_evt = split_req_i && !fits;

    pbs_limit_check #(.W(16)) u_limit (
        .limit_i     (split_limit),
        .committed_i (split_committed_i),
        .req_size_i  (split_req_size_i),
        .fits_o      (fits)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next values: set wins over clear
    wire logic next_discard;
    wire logic next_unexp;
    wire logic next_overrun;
    wire logic next_delay;
    assign next_discard = !reverse_mode_i && (cpl_discard_i || (discard_flag && !clr_discard));
    assign next_unexp   = reverse_mode_i && (unexp_evt || (unexp_flag && !clr_unexp));
    assign next_overrun = cpl_overrun_i || (overrun_flag && !clr_overrun);
    assign next_delay   = delay_evt || (delay_flag && !clr_delay);

    // strap taken straight from the pin on the release edge, so a read there is current
    wire logic wide_bit;
    assign wide_bit = rst_q ? (reverse_mode_i && !wide_request_strap_n_i) : wide_flag;

    // read image of the status word, upper bits zero
    wire logic [31:0] status_word;
    assign status_word = {10'h000, delay_flag, overrun_flag, unexp_flag, discard_flag,
                          reverse_mode_i, wide_bit, primary_bus_i, dev_num, func_num};

    wire logic [31:0] next_rdata;
    assign next_rdata = (reg_offset == PBS_STATUS_OFFSET) ? status_word :
                        (reg_offset == PBS_SPLIT_OFFSET)  ? {split_limit, PBS_CAP_VALUE} :
                        32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // device and function number capture
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            func_num <= PBS_FUNC_RESET;
            dev_num  <= PBS_DEV_RESET;
        end else if (hit_write) begin
            func_num <= cfg_addr_i[PBS_AD_FUNC_LSB +: 3];
            dev_num  <= cfg_addr_i[PBS_AD_DEV_LSB +: 5];
        end
    end

    // strap sampled on the first clock after reset release
    always_ff @(posedge core_clk_i) begin
        rst_q <= rst_i;
        if (rst_i) begin
            wide_flag <= 1'b0;
        end else if (rst_q) begin
            wide_flag <= reverse_mode_i && !wide_request_strap_n_i;
        end
    end

    // sticky split error flags
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            discard_flag <= 1'b0;
            unexp_flag   <= 1'b0;
            overrun_flag <= 1'b0;
            delay_flag   <= 1'b0;
        end else begin
            discard_flag <= next_discard;
            unexp_flag   <= next_unexp;
            overrun_flag <= next_overrun;
            delay_flag   <= next_delay;
        end
    end

    // commitment limit, upper half writable by lanes 2 and 3
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            split_limit <= PBS_LIMIT_RESET;
        end else if (wr_split) begin
            if (cfg_be_i[2]) split_limit[7:0]  <= cfg_wdata_i[23:16];
            if (cfg_be_i[3]) split_limit[15:8] <= cfg_wdata_i[31:24];
        end
    end

    // registered outputs
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cfg_rdata_o    <= 32'h0000_0000;
            cfg_rvalid_o   <= 1'b0;
            completer_id_o <= 16'hffff;
            split_fwd_o    <= 1'b0;
        end else begin
            cfg_rvalid_o   <= hit_read;
            cfg_rdata_o    <= hit_read ? next_rdata : 32'h0000_0000;
            completer_id_o <= own_id;
            split_fwd_o    <= split_req_i && fits;
        end
    end
endmodule : pbs_status_reg
`default_nettype wire

//--- tb/pbs_status_reg_chk.sv
// checker for the bridge primary status register
`timescale 1ns/100ps
`default_nettype none
module pbs_status_reg_chk
    import pbs_pkg::*;
(
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    input wire logic        reverse_mode_i,
    input wire logic        cfg_valid_i,
    input wire logic [3:0]  cfg_cmd_i,
    input wire logic        cfg_idsel_i,
    input wire logic [31:0] cfg_addr_i,
    input wire logic [7:0]  primary_bus_i,
    input wire logic        cpl_overrun_i,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic        cfg_rvalid_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // read of the status dword by function 0
    sequence s_rd84;
        cfg_valid_i && cfg_idsel_i && cfg_cmd_i == PBS_CMD_CFG_READ && cfg_addr_i[10:0] == 11'h084;
    endsequence
    a_rdata_idle: assert property (!cfg_rvalid_o |-> cfg_rdata_o == 32'h0)
        else $error("read data not zero while idle");
    a_no_answer: assert property (!(cfg_valid_i && cfg_idsel_i) |=> !cfg_rvalid_o)
        else $error("answer without selection");
    a_rsvd_zero: assert property (s_rd84 |=> cfg_rdata_o[31:22] == 10'h0)
        else $error("reserved bits not zero");
    a_bus_view: assert property (s_rd84 |=> cfg_rdata_o[15:8] == $past(primary_bus_i))
        else $error("bus number field wrong");
    a_fast_mode: assert property (s_rd84 |=> cfg_rdata_o[17] == $past(reverse_mode_i))
        else $error("fast capable bit wrong");
    a_wide_fwd: assert property (s_rd84 ##1 !reverse_mode_i |-> !cfg_rdata_o[16])
        else $error("wide bit set in forward mode");
    a_disc_rev: assert property (s_rd84 ##1 reverse_mode_i |-> !cfg_rdata_o[18])
        else $error("discard flag set in reverse mode");
    a_unexp_fwd: assert property (s_rd84 ##1 !reverse_mode_i |-> !cfg_rdata_o[19])
        else $error("unexpected flag set in forward mode");
    a_overrun_set: assert property (cpl_overrun_i ##1 s_rd84 |=> cfg_rdata_o[20])
        else $error("overrun flag not set");
endmodule : pbs_status_reg_chk
`default_nettype wire

//--- tb/pbs_cfg_host.sv
// configuration master model on the primary bus
`timescale 1ns/100ps
`default_nettype none
module pbs_cfg_host
    import pbs_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rvalid_i,
    input  wire logic [31:0] rdata_i,
    output var  logic        valid_o,
    output var  logic        idsel_o,
    output var  logic [3:0]  cmd_o,
    output var  logic [3:0]  be_o,
    output var  logic [31:0] addr_o,
    output var  logic [31:0] wdata_o
);
    // idle bus at time zero
    initial {valid_o, idsel_o, cmd_o, be_o, addr_o, wdata_o} = '0;
    // one address phase, then valid and idsel drop while address and data lines show inverted values
    task automatic access(input logic [3:0] c, input logic id, input logic [31:0] a, d,
                          output logic rv, output logic [31:0] rd);
        {valid_o, idsel_o, cmd_o, addr_o, wdata_o, be_o} = {1'b1, id, c, a, d, 4'hf};
        @(posedge core_clk_i);
        {valid_o, idsel_o, addr_o, wdata_o} <= {2'b00, ~a, ~d};
        @(negedge core_clk_i);
        {rv, rd} = {rvalid_i, rdata_i};
    endtask : access
endmodule : pbs_cfg_host
`default_nettype wire

//--- tb/testbench.sv
// testbench for the bridge primary status register
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import pbs_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, rev = 1'b0, strap_n = 1'b0, disc = 1'b0, arr = 1'b0;
    logic        ovr = 1'b0, sreq = 1'b0, valid, idsel, rvalid, fwd;
    logic [3:0]  cmd, be;
    logic [31:0] addr, wdata, rdata;
    logic [15:0] cid, rid = 16'h0, size = 16'h0, comm = 16'h0;
    logic        mixed = 1'b0;
    logic [7:0]  bus = 8'h5a;
    int          n_fail = 0, tests_run = 0;
    // 250 MHz clock
    always #2 clk = ~clk;
    pbs_status_reg u_dut (.core_clk_i(clk), .rst_i(rst), .reverse_mode_i(rev),
        .wide_request_strap_n_i(strap_n), .cfg_valid_i(valid), .cfg_cmd_i(cmd),
        .cfg_idsel_i(idsel), .cfg_addr_i(addr), .cfg_wdata_i(wdata), .cfg_be_i(be),
        .primary_bus_i(bus), .mixed_mode_i(mixed), .cpl_discard_i(disc), .cpl_arrive_i(arr),
        .cpl_req_id_i(rid), .cpl_overrun_i(ovr), .split_req_i(sreq), .split_req_size_i(size),
        .split_committed_i(comm), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
        .completer_id_o(cid), .split_fwd_o(fwd));
    pbs_cfg_host u_host (.core_clk_i(clk), .rvalid_i(rvalid), .rdata_i(rdata), .valid_o(valid),
        .idsel_o(idsel), .cmd_o(cmd), .be_o(be), .addr_o(addr), .wdata_o(wdata));
    task automatic chk(input string nm, input logic [31:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic rd(input logic [31:0] exp);
        logic        rv;
        logic [31:0] d;
        u_host.access(PBS_CMD_CFG_READ, 1'b1, 32'h84, 32'h0, rv, d);
        chk("rvalid", 32'h1, {31'h0, rv});
        chk("status", exp, d);
    endtask : rd
    task automatic wr(input logic id, input logic [31:0] a, d);
        logic        rv;
        logic [31:0] x;
        u_host.access(PBS_CMD_CFG_WRITE, id, a, d, rv, x);
        chk("write answer", 32'h0, {31'h0, rv});
    endtask : wr
    task automatic ev(input logic [3:0] e, input logic [15:0] i, s, c);
        {disc, arr, ovr, sreq, rid, size, comm} = {e, i, s, c};
        @(posedge clk);
        {disc, arr, ovr, sreq} <= 4'h0;
        @(negedge clk);
    endtask : ev
    task automatic do_reset(input logic r);
        {rst, rev} = {1'b1, r};
        repeat (20) @(negedge clk);
        rst = 1'b0;
    endtask : do_reset
    task automatic t_forward();
        rd(32'h00005af8);
        wr(1'b0, 32'h5088, 32'h0);
        wr(1'b1, 32'h5188, 32'h0);
        wr(1'b1, 32'h5089, 32'h0);
        rd(32'h00005af8);
        wr(1'b1, 32'h5088, 32'h0);
        rd(32'h00005a50);
        chk("completer id", 32'h5a50, {16'h0, cid});
        $display("test forward done");
    endtask : t_forward
    task automatic t_flags();
        ev(4'b1000, 16'h0, 16'h0, 16'h0);
        ev(4'b0100, 16'h5a50, 16'h0, 16'h0);
        ev(4'b0001, 16'h0, 16'h1, 16'h10);
        chk("held request", 32'h0, {31'h0, fwd});
        ev(4'b0010, 16'h0, 16'h0, 16'h0);
        rd(32'h00345a50);
        wr(1'b1, 32'h5084, 32'hffc40000);
        rd(32'h00305a50);
        wr(1'b1, 32'h5084, 32'h00300000);
        rd(32'h00005a50);
        ev(4'b0001, 16'h0, 16'h8, 16'h8);
        chk("fit request", 32'h1, {31'h0, fwd});
        wr(1'b1, 32'h508c, 32'hffff0010);
        ev(4'b0001, 16'h0, 16'h0100, 16'hff00);
        chk("open limit", 32'h1, {31'h0, fwd});
        rd(32'h00005a50);
        $display("test flags done");
    endtask : t_flags
    task automatic t_reverse();
        rd(32'h00035af8);
        ev(4'b0100, 16'h5af8, 16'h0, 16'h0);
        ev(4'b1000, 16'h0, 16'h0, 16'h0);
        rd(32'h000b5af8);
        wr(1'b1, 32'hf884, 32'h00080000);
        rd(32'h00035af8);
        $display("test reverse done");
    endtask : t_reverse
    task automatic t_strap();
        {strap_n, mixed} = 2'b11;
        do_reset(1'b1);
        rd(32'h00025af8);
        bus = 8'h3c;
        rd(32'h00023cf8);
        chk("completer id", 32'h3cf8, {16'h0, cid});
        $display("test strap done");
    endtask : t_strap
    task automatic print_verdict();
        $display("tests_run %0d n_fail %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    // main sequence
    initial begin
        do_reset(1'b0);
        t_forward();
        t_flags();
        do_reset(1'b1);
        t_reverse();
        t_strap();
        print_verdict();
    end
    // watchdog
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
endmodule : testbench
bind pbs_status_reg pbs_status_reg_chk u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .reverse_mode_i(reverse_mode_i), .cfg_valid_i(cfg_valid_i), .cfg_cmd_i(cfg_cmd_i),
    .cfg_idsel_i(cfg_idsel_i), .cfg_addr_i(cfg_addr_i), .primary_bus_i(primary_bus_i),
    .cpl_overrun_i(cpl_overrun_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o));
`default_nettype wire
